// [include/rtc_ccr_pkg.sv]
// constants, types and helpers of the clock/control register space
package rtc_ccr_pkg;

  localparam logic [6:0] DEV_ID        = 7'h6F;
  localparam logic [7:0] ADDR_LAST     = 8'h3F;
  localparam logic [5:0] ADDR_ALM0     = 6'h00;
  localparam logic [5:0] ADDR_ALM0_END = 6'h07;
  localparam logic [5:0] ADDR_ALM1     = 6'h08;
  localparam logic [5:0] ADDR_ALM1_END = 6'h0F;
  localparam logic [5:0] ADDR_CTRL     = 6'h10;
  localparam logic [5:0] ADDR_CTRL_END = 6'h14;
  localparam logic [5:0] ADDR_TIME     = 6'h30;
  localparam logic [5:0] ADDR_TIME_END = 6'h37;
  localparam logic [5:0] ADDR_STATUS   = 6'h3F;

  localparam int NV_BYTES   = 21;
  localparam int TIME_BYTES = 8;

  // time byte indices inside the time section
  localparam int T_SEC  = 0;
  localparam int T_MIN  = 1;
  localparam int T_HR   = 2;
  localparam int T_DAY  = 3;
  localparam int T_MON  = 4;
  localparam int T_YR   = 5;
  localparam int T_WDAY = 6;
  localparam int T_CEN  = 7;

  // status byte fields
  localparam int ST_BAT  = 7;
  localparam int ST_AL1  = 6;
  localparam int ST_AL0  = 5;
  localparam int ST_OSC_FAIL_FLAG = 4;
  localparam int ST_REGISTER_WRITE_LATCH = 2;
  localparam int ST_WEL  = 1;
  localparam int ST_LOSS = 0;
  localparam logic [7:0] STATUS_RESET    = 8'h01;
  localparam logic [7:0] STATUS_CLEAR    = 8'h00;
  localparam logic [7:0] STATUS_SET_WEL  = 8'h02;
  localparam logic [7:0] STATUS_SET_BOTH = 8'h06;

  // hours byte fields
  localparam int HR_MIL = 7;
  localparam int HR_PM  = 5;

  // bcd limits
  localparam logic [7:0] BCD_59   = 8'h59;
  localparam logic [7:0] BCD_23   = 8'h23;
  localparam logic [7:0] BCD_12   = 8'h12;
  localparam logic [7:0] BCD_11   = 8'h11;
  localparam logic [7:0] BCD_01   = 8'h01;
  localparam logic [7:0] BCD_00   = 8'h00;
  localparam logic [7:0] BCD_99   = 8'h99;
  localparam logic [7:0] BCD_28   = 8'h28;
  localparam logic [7:0] BCD_29   = 8'h29;
  localparam logic [7:0] BCD_30   = 8'h30;
  localparam logic [7:0] BCD_31   = 8'h31;
  localparam logic [7:0] CEN_LO   = 8'h19;
  localparam logic [7:0] CEN_HI   = 8'h20;
  localparam logic [2:0] WDAY_MAX = 3'h6;

  // reset values
  localparam logic [63:0] TIME_RESET = 64'h2000000100000000;
  localparam logic [7:0]  PWR_RESET  = 8'h40;
  localparam logic [7:0]  BL_RESET   = 8'h18;
  localparam logic [7:0]  CEN_RESET  = 8'h20;
  localparam logic [167:0] NV_RESET  = {PWR_RESET, 24'h000000, BL_RESET,
                                        CEN_RESET, 56'h0, CEN_RESET, 56'h0};

  // timebase
  localparam int SECOND_S = 1;
  localparam int OSC_HZ   = 32768;

  // sections of the register space
  localparam logic [2:0] SEC_ALM0 = 3'h0;
  localparam logic [2:0] SEC_ALM1 = 3'h1;
  localparam logic [2:0] SEC_CTRL = 3'h2;
  localparam logic [2:0] SEC_TIME = 3'h3;
  localparam logic [2:0] SEC_STAT = 3'h4;
  localparam logic [2:0] SEC_NONE = 3'h5;

  typedef enum logic [2:0] {
    PH_IDLE, PH_DEVADDR, PH_ADDRHI, PH_ADDRLO, PH_WDATA, PH_RDATA,
    PH_WAITSTOP
  } phase_t;

  function automatic logic [2:0] secOf(input logic [5:0] a);
    if (a <= ADDR_ALM0_END) return SEC_ALM0;
    if (a <= ADDR_ALM1_END) return SEC_ALM1;
    if (a <= ADDR_CTRL_END) return SEC_CTRL;
    if (a >= ADDR_TIME && a <= ADDR_TIME_END) return SEC_TIME;
    if (a == ADDR_STATUS) return SEC_STAT;
    return SEC_NONE;
  endfunction : secOf

  // next address, wrapping inside the section
  function automatic logic [5:0] nextInSec(input logic [5:0] a);
    case (secOf(a))
      SEC_ALM0: return (a == ADDR_ALM0_END) ? ADDR_ALM0 : a + 6'h01;
      SEC_ALM1: return (a == ADDR_ALM1_END) ? ADDR_ALM1 : a + 6'h01;
      SEC_CTRL: return (a == ADDR_CTRL_END) ? ADDR_CTRL : a + 6'h01;
      SEC_TIME: return (a == ADDR_TIME_END) ? ADDR_TIME : a + 6'h01;
      SEC_STAT: return ADDR_STATUS;
      default:  return a + 6'h01;
    endcase
  endfunction : nextInSec

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcdInc

  function automatic logic [7:0] lastDay(input logic [7:0] mon,
                                         input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02:                      return leap ? BCD_29 : BCD_28;
      8'h04, 8'h06, 8'h09, 8'h11: return BCD_30;
      default:                    return BCD_31;
    endcase
  endfunction : lastDay

endpackage : rtc_ccr_pkg

// [rtl/rtc_ccr.sv]
// clock/control register space of a serial-bus real time clock
// Behaviour
// - answer only slave byte 1101111x, decode addresses 0000h to 003Fh
// - five sections: alarm0 8, alarm1 8, control 5, time 8, status 1
// - writes buffered; alarm, control and time bytes commit only with both latches after valid stop
// - sequential access stays in one section, wrapping inside it
// - any start address inside the space is accepted
// - status byte writable without the register write latch
// - status access is one byte; continuing terminates the operation
// - read command snapshots time counters; read returns the snapshot
// - reads never return data from the memory array
// - after a read the pointer holds the next address inside the section, wrapping at its end
// - bcd counters: sec/min 00-59, day 1-31, month 1-12, year 0-99
// - weekday three bits counting 0 to 6, wraps, resets to zero
// - century holds only 19 or 20
// - 24h mode counts 0-23; 12h counts 1-12 with pm flag
// - february 29 in years divisible by four
// - backup supply flag read-only, follows supply state
// - alarm flags set on match; status read clears flags set at start
// - oscillator fail flag read-only, follows oscillator state
// - register write latch clears at reset, no write cycle
// - write enable latch low discards writes yet acknowledges bytes
// - 02h sets write enable latch, 00h clears both latches
// - total power loss flag set at reset, cleared by any committed time write
// - incomplete time write keeps current unwritten bytes; invalid century is discarded
// - new time loads at next second tick; counters keep running
`timescale 1ns/1ps

module rtc_ccr
  import rtc_ccr_pkg::*;
#(
  parameter int OSC_TICKS = SECOND_S * OSC_HZ
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic oscClk,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  input  wire logic backupSupply,
  input  wire logic oscStopped,
  input  wire logic alarm0Match,
  input  wire logic alarm1Match
);

  // pin synchronisers
  logic [5:0] pinS1_q;
  logic [5:0] pinS2_q;
  logic [1:0] busS3_q;
  logic [1:0] almS3_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinS1_q <= 6'h03;
      pinS2_q <= 6'h03;
      busS3_q <= 2'h3;
      almS3_q <= 2'h0;
    end else begin
      pinS1_q <= {alarm1Match, alarm0Match, oscStopped, backupSupply,
                  sdaIn, sclIn};
      pinS2_q <= pinS1_q;
      busS3_q <= pinS2_q[1:0];
      almS3_q <= pinS2_q[5:4];
    end
  end

  logic sclNow;
  logic sdaNow;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign sclNow    = pinS2_q[0];
  assign sdaNow    = pinS2_q[1];
  assign sclRise   = sclNow && !busS3_q[0];
  assign sclFall   = !sclNow && busS3_q[0];
  assign startCond = sclNow && busS3_q[0] && busS3_q[1] && !sdaNow;
  assign stopCond  = sclNow && busS3_q[0] && !busS3_q[1] && sdaNow;

  // oscillator domain: one-second toggle
  logic        oscRstS1_q;
  logic        oscRstS2_q;
  logic [15:0] prescale_q;
  logic        secTgl_q;

  always_ff @(posedge oscClk) begin
    oscRstS1_q <= rst;
    oscRstS2_q <= oscRstS1_q;
  end

  always_ff @(posedge oscClk) begin
    if (oscRstS2_q) begin
      prescale_q <= 16'h0000;
      secTgl_q   <= 1'b0;
    end else if (prescale_q == 16'(OSC_TICKS - 1)) begin
      prescale_q <= 16'h0000;
      secTgl_q   <= !secTgl_q;
    end else begin
      prescale_q <= prescale_q + 16'h0001;
    end
  end

  logic tglS1_q;
  logic tglS2_q;
  logic tglS3_q;
  logic secTick;

  always_ff @(posedge clk) begin
    if (rst) begin
      tglS1_q <= 1'b0;
      tglS2_q <= 1'b0;
      tglS3_q <= 1'b0;
    end else begin
      tglS1_q <= secTgl_q;
      tglS2_q <= tglS1_q;
      tglS3_q <= tglS2_q;
    end
  end

  assign secTick = tglS2_q ^ tglS3_q;

  // storage
  logic [7:0]  nv_q    [NV_BYTES];
  logic [7:0]  tm_q    [TIME_BYTES];
  logic [7:0]  snap_q  [TIME_BYTES];
  logic [7:0]  pend_q  [TIME_BYTES];
  logic [7:0]  wbuf_q  [64];
  logic [63:0] wmask_q;
  logic        pendValid_q;
  logic        wel_q;
  logic        register_write_latch_q;
  logic        loss_q;
  logic        al0_q;
  logic        al1_q;
  logic [1:0]  alArm_q;
  logic [7:0]  statusByte;

  assign statusByte = {pinS2_q[2], al1_q, al0_q, pinS2_q[3], 1'b0,
                       register_write_latch_q, wel_q, loss_q};

  // serial slave state
  phase_t     phase_q;
  logic [3:0] bitCnt_q;
  logic       afterAck_q;
  logic [7:0] shift_q;
  logic [5:0] ptr_q;
  logic       addrHiBad_q;
  logic       addrBad_q;
  logic       wrAny_q;
  logic [2:0] wrSec_q;
  logic       masterAck_q;
  logic       rdStat_q;
  logic [7:0] outByte_q;
  logic       sdaOe_q;
  logic       sdaOut_q;
  logic       commit_q;
  logic       snapTake_q;
  logic       statRdStart_q;
  logic       statRdEnd_q;
  logic [7:0] rdByte;

  always_comb begin
    case (secOf(ptr_q))
      SEC_ALM0, SEC_ALM1, SEC_CTRL: rdByte = nv_q[ptr_q[4:0]];
      SEC_TIME:                     rdByte = snap_q[ptr_q[2:0]];
      SEC_STAT:                     rdByte = statusByte;
      default:                      rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    commit_q      <= 1'b0;
    snapTake_q    <= 1'b0;
    statRdStart_q <= 1'b0;
    statRdEnd_q   <= 1'b0;
    if (rst) begin
      phase_q     <= PH_IDLE;
      bitCnt_q    <= 4'h0;
      afterAck_q  <= 1'b0;
      shift_q     <= 8'h00;
      ptr_q       <= 6'h00;
      addrHiBad_q <= 1'b0;
      addrBad_q   <= 1'b0;
      wrAny_q     <= 1'b0;
      wrSec_q     <= SEC_NONE;
      masterAck_q <= 1'b0;
      rdStat_q    <= 1'b0;
      outByte_q   <= 8'h00;
      sdaOe_q     <= 1'b0;
      wmask_q     <= 64'h0;
    end else if (startCond) begin
      // a repeated start abandons any buffered write
      phase_q    <= PH_DEVADDR;
      bitCnt_q   <= 4'h0;
      afterAck_q <= 1'b0;
      rdStat_q   <= 1'b0;
      sdaOe_q    <= 1'b0;
      wrAny_q    <= 1'b0;
      wmask_q    <= 64'h0;
    end else if (stopCond) begin
      if (wrAny_q && !addrBad_q) begin
        commit_q <= 1'b1;
      end
      phase_q <= PH_IDLE;
      sdaOe_q <= 1'b0;
    end else if (phase_q != PH_IDLE && sclRise) begin
      if (bitCnt_q == 4'h8) begin
        bitCnt_q <= 4'h0;
        if (phase_q == PH_RDATA) begin
          masterAck_q <= !sdaNow;
          if (sdaNow || rdStat_q) begin
            phase_q <= PH_WAITSTOP;
          end
        end
      end else begin
        bitCnt_q <= bitCnt_q + 4'h1;
        shift_q  <= {shift_q[6:0], sdaNow};
      end
    end else if (phase_q != PH_IDLE && sclFall) begin
      if (bitCnt_q == 4'h8) begin
        afterAck_q <= 1'b1;
        sdaOe_q    <= 1'b0;
        case (phase_q)
          PH_DEVADDR: begin
            if (shift_q[7:1] == DEV_ID) begin
              sdaOe_q <= 1'b1;
              if (shift_q[0]) begin
                phase_q     <= PH_RDATA;
                masterAck_q <= 1'b1;
                snapTake_q  <= 1'b1;
              end else begin
                phase_q <= PH_ADDRHI;
              end
            end else begin
              phase_q <= PH_IDLE;
            end
          end
          PH_ADDRHI: begin
            sdaOe_q     <= 1'b1;
            addrHiBad_q <= shift_q != 8'h00;
            phase_q     <= PH_ADDRLO;
          end
          PH_ADDRLO: begin
            sdaOe_q   <= 1'b1;
            ptr_q     <= shift_q[5:0];
            addrBad_q <= addrHiBad_q || shift_q > ADDR_LAST;
            phase_q   <= PH_WDATA;
          end
          PH_WDATA: begin
            if (wrAny_q && ptr_q == ADDR_STATUS) begin
              phase_q <= PH_WAITSTOP;
            end else begin
              sdaOe_q        <= 1'b1;
              wbuf_q[ptr_q]  <= shift_q;
              wmask_q[ptr_q] <= 1'b1;
              wrAny_q        <= 1'b1;
              wrSec_q        <= secOf(ptr_q);
              ptr_q          <= nextInSec(ptr_q);
            end
          end
          PH_RDATA: begin
            ptr_q <= nextInSec(ptr_q);
            if (rdStat_q) begin
              statRdEnd_q <= 1'b1;
            end
          end
          default: begin
            sdaOe_q <= 1'b0;
          end
        endcase
      end else if (bitCnt_q == 4'h0 && afterAck_q) begin
        afterAck_q <= 1'b0;
        sdaOe_q    <= 1'b0;
        if (phase_q == PH_RDATA && masterAck_q) begin
          outByte_q <= rdByte;
          sdaOe_q   <= !rdByte[7];
          rdStat_q  <= ptr_q == ADDR_STATUS;
          if (ptr_q == ADDR_STATUS) begin
            statRdStart_q <= 1'b1;
          end
        end
      end else if (phase_q == PH_RDATA && masterAck_q
                   && bitCnt_q != 4'h0) begin
        sdaOe_q <= !outByte_q[~bitCnt_q[2:0]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sdaOut_q <= 1'b0;
    end else begin
      sdaOut_q <= 1'b0;
    end
  end

  assign sdaOut = sdaOut_q;
  assign sdaOe  = sdaOe_q;

  logic commitStat;
  logic commitNv;
  logic commitTime;

  assign commitStat = commit_q && wrSec_q == SEC_STAT;
  assign commitNv   = commit_q && wel_q && register_write_latch_q
                      && wrSec_q <= SEC_CTRL;
  assign commitTime = commit_q && wel_q && register_write_latch_q
                      && wrSec_q == SEC_TIME;

  // write latches and power loss flag
  always_ff @(posedge clk) begin
    if (rst) begin
      wel_q  <= STATUS_RESET[ST_WEL];
      register_write_latch_q <= STATUS_RESET[ST_REGISTER_WRITE_LATCH];
      loss_q <= STATUS_RESET[ST_LOSS];
    end else begin
      if (commitStat) begin
        if (wbuf_q[ADDR_STATUS] == STATUS_CLEAR) begin
          wel_q  <= 1'b0;
          register_write_latch_q <= 1'b0;
        end else if (wbuf_q[ADDR_STATUS] == STATUS_SET_WEL) begin
          wel_q  <= 1'b1;
          register_write_latch_q <= 1'b0;
        end else if (wbuf_q[ADDR_STATUS] == STATUS_SET_BOTH && wel_q) begin
          register_write_latch_q <= 1'b1;
        end
      end
      if (commitTime) begin
        loss_q <= 1'b0;
      end
    end
  end

  // alarm flags, set wins over the read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      al0_q   <= 1'b0;
      al1_q   <= 1'b0;
      alArm_q <= 2'h0;
    end else begin
      if (statRdStart_q) begin
        alArm_q <= {al1_q, al0_q};
      end
      if (pinS2_q[4] && !almS3_q[0]) begin
        al0_q <= 1'b1;
      end else if (statRdEnd_q && alArm_q[0]) begin
        al0_q <= 1'b0;
      end
      if (pinS2_q[5] && !almS3_q[1]) begin
        al1_q <= 1'b1;
      end else if (statRdEnd_q && alArm_q[1]) begin
        al1_q <= 1'b0;
      end
    end
  end

  // alarm and control bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NV_BYTES; i++) begin
        nv_q[i] <= NV_RESET[8*i +: 8];
      end
    end else if (commitNv) begin
      for (int i = 0; i < NV_BYTES; i++) begin
        if (wmask_q[i]) begin
          nv_q[i] <= wbuf_q[i];
        end
      end
    end
  end

  // next time value on a one-second tick
  logic [7:0] nx [TIME_BYTES];
  logic       cMin;
  logic       cHr;
  logic       cDay;
  logic       cMon;
  logic       cYr;
  logic [7:0] hrInc;

  always_comb begin
    for (int i = 0; i < TIME_BYTES; i++) begin
      nx[i] = tm_q[i];
    end
    hrInc = 8'h00;
    cMin = tm_q[T_SEC] == BCD_59;
    cHr  = 1'b0;
    cDay = 1'b0;
    cMon = 1'b0;
    cYr  = 1'b0;
    nx[T_SEC] = cMin ? BCD_00 : bcdInc(tm_q[T_SEC]);
    if (cMin) begin
      cHr       = tm_q[T_MIN] == BCD_59;
      nx[T_MIN] = cHr ? BCD_00 : bcdInc(tm_q[T_MIN]);
    end
    if (cHr) begin
      if (tm_q[T_HR][HR_MIL]) begin
        cDay = tm_q[T_HR][5:0] == BCD_23[5:0];
        hrInc         = bcdInc({2'b00, tm_q[T_HR][5:0]});
        nx[T_HR][5:0] = cDay ? 6'h00 : hrInc[5:0];
      end else if (tm_q[T_HR][4:0] == BCD_12[4:0]) begin
        nx[T_HR][4:0] = BCD_01[4:0];
      end else if (tm_q[T_HR][4:0] == BCD_11[4:0]) begin
        nx[T_HR][4:0]  = BCD_12[4:0];
        nx[T_HR][HR_PM] = !tm_q[T_HR][HR_PM];
        cDay            = tm_q[T_HR][HR_PM];
      end else begin
        hrInc         = bcdInc({3'b000, tm_q[T_HR][4:0]});
        nx[T_HR][4:0] = hrInc[4:0];
      end
    end
    if (cDay) begin
      nx[T_WDAY] = (tm_q[T_WDAY][2:0] == WDAY_MAX) ? 8'h00
                 : {5'b00000, tm_q[T_WDAY][2:0] + 3'h1};
      cMon = tm_q[T_DAY] == lastDay(tm_q[T_MON], tm_q[T_YR]);
      nx[T_DAY] = cMon ? BCD_01 : bcdInc(tm_q[T_DAY]);
    end
    if (cMon) begin
      cYr       = tm_q[T_MON] == BCD_12;
      nx[T_MON] = cYr ? BCD_01 : bcdInc(tm_q[T_MON]);
    end
    if (cYr) begin
      nx[T_YR] = (tm_q[T_YR] == BCD_99) ? BCD_00 : bcdInc(tm_q[T_YR]);
      if (tm_q[T_YR] == BCD_99) begin
        nx[T_CEN] = CEN_HI;
      end
    end
  end

  // buffered time write, loaded on the next tick
  always_ff @(posedge clk) begin
    if (rst) begin
      pendValid_q <= 1'b0;
      for (int i = 0; i < TIME_BYTES; i++) begin
        pend_q[i] <= TIME_RESET[8*i +: 8];
      end
    end else if (commitTime) begin
      pendValid_q <= 1'b1;
      for (int i = 0; i < TIME_BYTES; i++) begin
        pend_q[i] <= wmask_q[ADDR_TIME + i] ? wbuf_q[ADDR_TIME + i]
                                            : tm_q[i];
      end
      pend_q[T_WDAY] <= wmask_q[ADDR_TIME + T_WDAY]
                        ? {5'b00000, wbuf_q[ADDR_TIME + T_WDAY][2:0]}
                        : tm_q[T_WDAY];
    end else if (secTick) begin
      pendValid_q <= 1'b0;
    end
  end

  // time counters
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < TIME_BYTES; i++) begin
        tm_q[i] <= TIME_RESET[8*i +: 8];
      end
    end else if (secTick && pendValid_q) begin
      for (int i = 0; i < TIME_BYTES; i++) begin
        tm_q[i] <= pend_q[i];
      end
      if (pend_q[T_CEN] != CEN_LO && pend_q[T_CEN] != CEN_HI) begin
        tm_q[T_CEN] <= tm_q[T_CEN];
      end
    end else if (secTick && !loss_q && !pinS2_q[3]) begin
      for (int i = 0; i < TIME_BYTES; i++) begin
        tm_q[i] <= nx[i];
      end
    end
  end

  // snapshot for reads
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < TIME_BYTES; i++) begin
        snap_q[i] <= TIME_RESET[8*i +: 8];
      end
    end else if (snapTake_q) begin
      for (int i = 0; i < TIME_BYTES; i++) begin
        snap_q[i] <= tm_q[i];
      end
    end
  end

endmodule : rtc_ccr

// [sim/i2c_host_model.sv]
// serial bus host model facing the register space
`timescale 1ns/1ps

module i2c_host_model (
  input  wire logic clk,
  input  wire logic sdaOe,
  output logic      scl,
  output logic      sda
);
  localparam int HALF = 12;
  logic hostLow;
  assign sda = !(hostLow || sdaOe);
  initial begin
    scl     = 1'b1;
    hostLow = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // start or repeated start opens a new operation
  task automatic start();
    hold(4);
    hostLow = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    hostLow = 1'b1;
    hold(HALF);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    hold(4);
    hostLow = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    hostLow = 1'b0;
    hold(HALF);
  endtask : stop
  task automatic bitx(input logic b, output logic r);
    hold(4);
    hostLow = !b;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    r = sda;
    scl = 1'b0;
  endtask : bitx
  task automatic wrb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask : wrb
  task automatic rdb(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask : rdb
endmodule : i2c_host_model

// [sim/rtc_ccr_props.sv]
// pin-level assertions for the register space
`timescale 1ns/1ps

module rtc_ccr_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic oscClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic backupSupply,
  input wire logic oscStopped,
  input wire logic alarm0Match,
  input wire logic alarm1Match
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence sStart;
    sclIn && $past(sclIn) && $fell(sdaIn);
  endsequence
  sequence sStop;
    sclIn && $past(sclIn) && $rose(sdaIn);
  endsequence

  a_out_low: assert property (sdaOut == 1'b0)
    else $error("sda value not low");
  a_start_quiet: assert property (sStart |=> !sdaOe [*6])
    else $error("drive during slave byte");
  a_stop_quiet: assert property (sStop |=> !sdaOe [*6])
    else $error("drive after stop");
  a_high_stable: assert property (
    sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("sda moved while scl high");
  a_change_low: assert property (
    $changed(sdaOe) |-> !sclIn && !$past(sclIn))
    else $error("sda moved near scl rise");
  a_ack_hold: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("drive too short");
  a_drive_bound: assert property ($rose(sdaOe) |-> ##[1:300] !sdaOe)
    else $error("drive never released");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !sdaOe)
    else $error("drive during reset");
endmodule : rtc_ccr_props

bind rtc_ccr rtc_ccr_props rtc_ccr_props_i (.clk(clk), .rst(rst),
  .oscClk(oscClk), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .backupSupply(backupSupply), .oscStopped(oscStopped),
  .alarm0Match(alarm0Match), .alarm1Match(alarm1Match));

// [sim/rtc_ccr_tb_top.sv]
// self-checking bench of the register space
`timescale 1ns/1ps

module rtc_ccr_tb_top;
  import rtc_ccr_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] v;} row_t;
  logic clk, rst, oscClk, scl, sda, sdaOut, sdaOe;
  logic backupSupply, oscStopped, alarm0Match, alarm1Match;
  int   mismatches, checkCount;
  logic ack;
  logic [7:0] q[$];
  logic [7:0] yr[2] = '{8'h04, 8'h05};
  logic [7:0] dy[2] = '{8'h29, 8'h01};
  logic [7:0] mo[2] = '{8'h02, 8'h03};
  row_t rows[9] = '{'{8'h3F, 8'h01}, '{8'h30, 8'h00}, '{8'h34, 8'h01},
    '{8'h37, 8'h20}, '{8'h07, 8'h20}, '{8'h0F, 8'h20}, '{8'h10, 8'h18},
    '{8'h14, 8'h40}, '{8'h00, 8'h00}};

  rtc_ccr #(.OSC_TICKS(8)) rtc_ccr_i (.clk(clk), .rst(rst), .oscClk(oscClk),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .backupSupply(backupSupply), .oscStopped(oscStopped),
    .alarm0Match(alarm0Match), .alarm1Match(alarm1Match));
  i2c_host_model i2c_host_model_i (.clk(clk), .sdaOe(sdaOe), .scl(scl),
    .sda(sda));

  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  initial begin
    oscClk = 1'b0;
    #7;
    forever #24 oscClk = !oscClk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkAck(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chkAck
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$],
                    input logic rs, output logic all);
    logic k;
    logic [7:0] s[$];
    s = {8'h00, a, d};
    i2c_host_model_i.start();
    i2c_host_model_i.wrb(8'hDE, all);
    foreach (s[i]) begin
      i2c_host_model_i.wrb(s[i], k);
      all &= k;
    end
    if (rs) i2c_host_model_i.start();
    i2c_host_model_i.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n, input logic cur,
                    output logic [7:0] r[$]);
    logic k;
    logic [7:0] b;
    r = {};
    if (!cur) begin
      i2c_host_model_i.start();
      i2c_host_model_i.wrb(8'hDE, k);
      i2c_host_model_i.wrb(8'h00, k);
      i2c_host_model_i.wrb(a, k);
    end
    i2c_host_model_i.start();
    i2c_host_model_i.wrb(8'hDF, k);
    for (int i = 0; i < n; i++) begin
      i2c_host_model_i.rdb(i == n - 1, b);
      r.push_back(b);
    end
    i2c_host_model_i.stop();
  endtask : rd
  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : endSim

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    endSim();
  end

  initial begin
    {rst, backupSupply, oscStopped, alarm0Match, alarm1Match} = 5'h10;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, 1, 1'b0, q);
      chk(q[0], rows[i].v);
    end
    $display("test reset values done");
    i2c_host_model_i.start();
    i2c_host_model_i.wrb(8'hA0, ack);
    chkAck(ack, 1'b0);
    i2c_host_model_i.stop();
    wr(8'h32, '{8'h85}, 1'b0, ack);
    chkAck(ack, 1'b1);
    wr(8'h3F, '{8'h06}, 1'b0, ack);
    rd(8'h32, 1, 1'b0, q);
    chk(q[0], 8'h00);
    rd(8'h3F, 1, 1'b0, q);
    chk(q[0], 8'h01);
    wr(8'h3F, '{8'h02}, 1'b0, ack);
    wr(8'h3F, '{8'h06}, 1'b0, ack);
    wr(8'h3F, '{8'h06, 8'h06}, 1'b0, ack);
    chkAck(ack, 1'b0);
    wr(8'h3F, '{8'h08}, 1'b0, ack);
    rd(8'h3F, 1, 1'b0, q);
    chk(q[0], 8'h07);
    wr(8'h32, '{8'h85}, 1'b1, ack);
    rd(8'h32, 1, 1'b0, q);
    chk(q[0], 8'h00);
    $display("test latches done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h30, '{8'h59, 8'h59, 8'hA3, 8'h28, 8'h02, yr[i], 8'h06, 8'h20},
         1'b0, ack);
      repeat (40) @(negedge clk);
      rd(8'h32, 6, 1'b0, q);
      chk(q[0], 8'h80);
      chk(q[1], dy[i]);
      chk(q[2], mo[i]);
      chk(q[3], yr[i]);
      chk(q[4], 8'h00);
      chk(q[5], 8'h20);
    end
    rd(8'h3F, 1, 1'b0, q);
    chk(q[0], 8'h06);
    rd(8'h34, 1, 1'b0, q);
    rd(8'h00, 1, 1'b1, q);
    chk(q[0], 8'h05);
    rd(8'h14, 2, 1'b0, q);
    chk(q[1], 8'h18);
    rd(8'h15, 1, 1'b0, q);
    chk(q[0], 8'h00);
    wr(8'h37, '{8'h21}, 1'b0, ack);
    rd(8'h37, 1, 1'b0, q);
    chk(q[0], 8'h20);
    wr(8'h30, '{8'h59, 8'h59, 8'h31}, 1'b0, ack);
    rd(8'h32, 1, 1'b0, q);
    chk(q[0], 8'h12);
    $display("test calendar done");
    {backupSupply, oscStopped, alarm0Match, alarm1Match} = 4'hF;
    rd(8'h3F, 1, 1'b0, q);
    chk(q[0], 8'hF6);
    {backupSupply, oscStopped, alarm0Match, alarm1Match} = 4'h0;
    rd(8'h3F, 1, 1'b0, q);
    chk(q[0], 8'h06);
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd(8'h3F, 1, 1'b0, q);
    chk(q[0], 8'h01);
    $display("test flags and reset done");
    endSim();
  end
endmodule : rtc_ccr_tb_top
